/* verilog/cfalc_core.sv */
// Instruction flow sequencer, single-instruction loop and multi-bit shifter.
// Assumes the decoder presents one instruction class per cycle on the
// same clock, and software reaches the registers over AXI4-Lite.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: Shifter moves up to fifteen bits right (arithmetic) or left in one cycle.
// RULE_02: Shift operand and result live only in registers, no data space path.
// RULE_03: Shifter offers arithmetic right, logical right and left shifts.
// RULE_04: Next word is prefetched while the current one executes.
// RULE_05: Flow changes discard the prefetched word, taking two cycles.
// RULE_06: Double-word load or store does two data accesses in two cycles.
// RULE_07: Table access suspends fetch, holds fetched word one cycle, then runs it.
// RULE_08: Two-word jump or call consumes the next fetched word as operand.
// RULE_09: An orphan second word executes as a no-operation.
// RULE_10: A write-read address dependency adds one stall cycle.
// RULE_11: Loop count comes from literal or register; target runs count plus one.
// RULE_12: Loop count sits in a 14-bit mapped counter loaded by the loop.
// RULE_13: Loop sets the active flag, status bit 4, when count is non-zero.
// RULE_14: The active flag is read-only to software.
// RULE_15: While count is above zero the program counter is held.
// RULE_16: Zero count acts as no-operation; target runs once with normal prefetch.
// RULE_17: Exception entry stacks the flag with status low byte, then clears it.
// RULE_18: Return restores the flag from popped byte and prefetches target in cycle three.
// RULE_19: Handler software saves and restores the loop counter around nested loops.
// RULE_20: A window-reading target takes two cycles on first run after return.
// RULE_21: Software clearing the counter in a handler ends the loop early.
// RULE_22: Software never places flow, loop or listed special ops as loop target.
// RULE_23: Counter decrements per target run; exhausted count clears flag and resumes.
module cfalc_core
   import cfalc_pkg::*;
(
   input wire logic aclk, // Instruction-cycle clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire cfalc_instr_type instr, // Decoded instruction offered
   output logic instr_ready, // Instruction taken this cycle
   output cfalc_ctl_type ctl, // Pipeline control strobes
   input wire logic [5:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [5:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic cfalc_reg_sel_type reg_sel(input logic [5:0] addr);
      cfalc_reg_sel_type r;
      r = RS_NONE;
      case ({addr[5:2], 2'h0})
         OFS_LOOP_COUNT: r = RS_COUNT;
         OFS_STATUS: r = RS_STATUS;
         OFS_SHIFT_CTRL: r = RS_SHCTL;
         OFS_SHIFT_RES: r = RS_SHRES;
         default: r = RS_NONE;
      endcase
      return r;
   endfunction : reg_sel

   function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_strb

   // Barrel shift; the amount field is 4 bits, so 15 is the widest move
   function automatic logic [15:0] shift_fn(input cfalc_shift_op_type op,
                                            input logic [15:0] v,
                                            input logic [3:0] amt);
      logic [15:0] r;
      r = v;
      case (op)
         SH_ASR: r = 16'($signed(v) >>> amt); // RULE_01 RULE_03
         SH_LSR: r = v >> amt; // RULE_03
         SH_SL: r = v << amt; // RULE_01 RULE_03
         default: r = v;
      endcase
      return r;
   endfunction : shift_fn

   function automatic logic [7:0] status_low(input cfalc_state_type st);
      logic [7:0] r;
      r = st.srl_rest & ~LOOP_ACTIVE_MASK;
      r[LOOP_ACTIVE_BIT] = st.loop_act;
      return r;
   endfunction : status_low

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cfalc_state_type s_q;
   cfalc_state_type s_d;
   cfalc_ctl_type c;
   logic ready;
   logic need_xtra;
   logic is_target;
   logic [13:0] new_cnt;
   logic aw_now;
   logic w_now;
   logic [5:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [31:0] old_word;
   logic [31:0] new_word;
   cfalc_reg_sel_type wsel;
   cfalc_reg_sel_type rsel;

   always_comb
   begin
      s_d = s_q;
      c = '0;
      ready = 1'b0;
      need_xtra = 1'b0;
      is_target = 1'b0;
      new_cnt = '0;
      c.srl_out = status_low(s_q);

      // ----------------------------------------------------------------
      // Flow sequencer
      // ----------------------------------------------------------------
      case (s_q.st)
         FS_RUN:
         begin
            c.pc_inc = 1'b1; // RULE_04
            c.fetch_en = 1'b1; // RULE_04
            if (instr.valid)
            begin
               // Stall and first window access both occupy the slot before execution
               need_xtra = instr.raw_dep // RULE_10
                  || (s_q.loop_act && s_q.psv_first && instr.program_space_window); // RULE_20
               if (need_xtra && !s_q.xtra_done)
               begin
                  c.stall = 1'b1; // RULE_10 RULE_20
                  c.pc_inc = 1'b0;
                  c.fetch_en = 1'b0;
                  s_d.xtra_done = 1'b1;
               end
               else
               begin
                  ready = 1'b1;
                  s_d.xtra_done = 1'b0;
                  case (instr.cls)
                     IC_FLOW:
                     begin
                        c.discard = 1'b1; // RULE_05
                        s_d.st = FS_FLUSH; // RULE_05
                     end
                     IC_DOUBLE:
                     begin
                        s_d.st = FS_DATA2; // RULE_06
                     end
                     IC_TABLE:
                     begin
                        s_d.st = FS_TABLE; // RULE_07
                     end
                     IC_TWO_WORD:
                     begin
                        s_d.st = FS_OPND; // RULE_08
                     end
                     IC_ORPHAN:
                     begin
                        c.exec_nop = 1'b1; // RULE_09
                     end
                     IC_LOOP_LIT, IC_LOOP_REG:
                     begin
                        new_cnt = (instr.cls == IC_LOOP_LIT) ? instr.lit
                           : instr.wreg[LOOP_W-1:0]; // RULE_11
                        s_d.loop_cnt = new_cnt; // RULE_12
                        s_d.loop_act = (new_cnt != 14'h0000); // RULE_13 RULE_16
                        s_d.psv_first = 1'b0;
                     end
                     IC_RETURN:
                     begin
                        c.discard = 1'b1;
                        s_d.st = FS_RET2;
                     end
                     IC_EXCEPT:
                     begin
                        c.push_srl = 1'b1; // RULE_17
                        c.discard = 1'b1;
                        s_d.loop_act = 1'b0; // RULE_17
                        s_d.st = FS_FLUSH;
                     end
                     default:
                     begin
                        c.exec_nop = 1'b0;
                     end
                  endcase

                  // Repeated target: the prefetched word stays put until the count runs out
                  is_target = s_q.loop_act && (instr.cls != IC_LOOP_LIT)
                     && (instr.cls != IC_LOOP_REG) && (instr.cls != IC_RETURN)
                     && (instr.cls != IC_EXCEPT);
                  if (is_target)
                  begin
                     c.loop_exec = 1'b1;
                     s_d.psv_first = 1'b0;
                     if (s_q.loop_cnt != 14'h0000)
                     begin
                        c.pc_inc = 1'b0; // RULE_15
                        c.fetch_en = 1'b0; // RULE_15
                        s_d.loop_cnt = s_q.loop_cnt - 14'h0001; // RULE_23
                     end
                     else
                     begin
                        s_d.loop_act = 1'b0; // RULE_23 RULE_21
                     end
                  end
               end
            end
         end
         FS_FLUSH:
         begin
            c.pc_inc = 1'b1; // RULE_05
            c.fetch_en = 1'b1;
            s_d.st = FS_RUN;
         end
         FS_DATA2:
         begin
            c.data_second = 1'b1; // RULE_06
            s_d.st = FS_RUN;
         end
         FS_TABLE:
         begin
            c.table_access = 1'b1; // RULE_07
            c.ir_hold = 1'b1; // RULE_07
            s_d.st = FS_RUN;
         end
         FS_OPND:
         begin
            c.operand_fetch = 1'b1; // RULE_08
            c.pc_inc = 1'b1;
            c.fetch_en = 1'b1;
            s_d.st = FS_RUN;
         end
         FS_RET2:
         begin
            c.pop_srl = 1'b1;
            s_d.st = FS_RET3;
         end
         FS_RET3:
         begin
            // Popped byte is presented by the stack path in this cycle
            c.fetch_en = 1'b1; // RULE_18
            c.pc_inc = 1'b1;
            s_d.loop_act = instr.popped_srl[LOOP_ACTIVE_BIT]; // RULE_18
            s_d.srl_rest = instr.popped_srl & ~LOOP_ACTIVE_MASK;
            s_d.psv_first = instr.popped_srl[LOOP_ACTIVE_BIT]; // RULE_20
            s_d.st = FS_RUN;
         end
         default:
         begin
            s_d.st = FS_RUN;
         end
      endcase

      // ----------------------------------------------------------------
      // Shifter, fed only from its own operand register
      // ----------------------------------------------------------------
      s_d.shf_res = shift_fn(s_q.shf_op, s_q.shf_src, s_q.shf_amt); // RULE_02

      // ----------------------------------------------------------------
      // AXI4-Lite write path
      // ----------------------------------------------------------------
      aw_now = s_q.aw_got || s_axi_awvalid;
      w_now = s_q.w_got || s_axi_wvalid;
      wr_addr = s_q.aw_got ? s_q.aw_addr : s_axi_awaddr;
      wr_data = s_q.w_got ? s_q.w_data : s_axi_wdata;
      wr_strb = s_q.w_got ? s_q.w_strb : s_axi_wstrb;
      wsel = reg_sel(wr_addr);
      old_word = '0;
      case (wsel)
         RS_COUNT: old_word = {18'h00000, s_q.loop_cnt};
         RS_STATUS: old_word = {24'h000000, status_low(s_q)};
         RS_SHCTL: old_word = {10'h000, s_q.shf_op, s_q.shf_amt, s_q.shf_src};
         default: old_word = '0;
      endcase
      new_word = merge_strb(old_word, wr_data, wr_strb);

      if (!s_q.bvalid && s_axi_awvalid && !s_q.aw_got)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (!s_q.bvalid && s_axi_wvalid && !s_q.w_got)
      begin
         s_d.w_got = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (!s_q.bvalid && aw_now && w_now)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = (wsel == RS_NONE) ? RESP_SLVERR : RESP_OKAY;
         case (wsel)
            // Software write outranks the loop's own decrement in the same cycle
            RS_COUNT: s_d.loop_cnt = new_word[LOOP_W-1:0]; // RULE_12 RULE_21
            RS_STATUS: s_d.srl_rest = new_word[7:0] & ~LOOP_ACTIVE_MASK; // RULE_14
            RS_SHCTL:
            begin
               s_d.shf_src = new_word[15:0]; // RULE_02
               s_d.shf_amt = new_word[SHCTL_AMT_LSB +: 4];
               s_d.shf_op = cfalc_shift_op_type'(new_word[SHCTL_OP_LSB +: 2]);
            end
            default:
            begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      else if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end

      // ----------------------------------------------------------------
      // AXI4-Lite read path
      // ----------------------------------------------------------------
      rsel = reg_sel(s_axi_araddr);
      if (!s_q.rvalid && s_axi_arvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         case (rsel)
            RS_COUNT: s_d.rdata = {18'h00000, s_q.loop_cnt};
            RS_STATUS: s_d.rdata = {24'h000000, status_low(s_q)}; // RULE_13
            RS_SHCTL: s_d.rdata = {10'h000, s_q.shf_op, s_q.shf_amt, s_q.shf_src};
            RS_SHRES: s_d.rdata = {16'h0000, s_q.shf_res};
            default:
            begin
               s_d.rdata = '0;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= '0;
         s_q.st <= FS_RUN;
         s_q.loop_cnt <= LOOP_COUNT_RST;
         s_q.srl_rest <= STATUS_LOW_RST;
         s_q.shf_op <= SH_ASR;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign instr_ready = ready;
   assign ctl = c;
   assign s_axi_awready = !s_q.bvalid && !s_q.aw_got;
   assign s_axi_wready = !s_q.bvalid && !s_q.w_got;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

endmodule : cfalc_core

`default_nettype wire

/* verilog/cfalc_pkg.sv */
// Shared constants and types of the flow and loop controller.
// Assumes one instruction-cycle clock; registers sit behind AXI4-Lite.
package cfalc_pkg;

   // ----------------------------------------------------------------
   // Widths and field positions
   // ----------------------------------------------------------------
   localparam int unsigned LOOP_W = 14;
   localparam int unsigned LOOP_ACTIVE_BIT = 4;
   localparam int unsigned SHCTL_AMT_LSB = 16;
   localparam int unsigned SHCTL_OP_LSB = 20;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses) and reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_LOOP_COUNT = 6'h00;
   localparam logic [5:0] OFS_STATUS = 6'h04;
   localparam logic [5:0] OFS_SHIFT_CTRL = 6'h08;
   localparam logic [5:0] OFS_SHIFT_RES = 6'h0C;
   localparam logic [13:0] LOOP_COUNT_RST = 14'h0000;
   localparam logic [7:0] STATUS_LOW_RST = 8'h00;
   localparam logic [7:0] LOOP_ACTIVE_MASK = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      IC_SINGLE, IC_FLOW, IC_DOUBLE, IC_TABLE, IC_TWO_WORD,
      IC_ORPHAN, IC_LOOP_LIT, IC_LOOP_REG, IC_RETURN, IC_EXCEPT
   } cfalc_iclass_type;

   typedef enum logic [2:0] {
      FS_RUN, FS_FLUSH, FS_DATA2, FS_TABLE, FS_OPND, FS_RET2, FS_RET3
   } cfalc_flow_state_type;

   typedef enum logic [1:0] {
      SH_ASR, SH_LSR, SH_SL, SH_PASS
   } cfalc_shift_op_type;

   typedef enum logic [2:0] {
      RS_COUNT, RS_STATUS, RS_SHCTL, RS_SHRES, RS_NONE
   } cfalc_reg_sel_type;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      cfalc_iclass_type cls;
      logic raw_dep;
      logic program_space_window;
      logic [13:0] lit;
      logic [15:0] wreg;
      logic [7:0] popped_srl;
   } cfalc_instr_type;

   typedef struct packed {
      logic pc_inc;
      logic fetch_en;
      logic discard;
      logic ir_hold;
      logic table_access;
      logic exec_nop;
      logic stall;
      logic operand_fetch;
      logic data_second;
      logic push_srl;
      logic pop_srl;
      logic loop_exec;
      logic [7:0] srl_out;
   } cfalc_ctl_type;

   typedef struct packed {
      cfalc_flow_state_type st;
      logic [13:0] loop_cnt;
      logic loop_act;
      logic [7:0] srl_rest;
      logic psv_first;
      logic xtra_done;
      logic [15:0] shf_src;
      logic [3:0] shf_amt;
      cfalc_shift_op_type shf_op;
      logic [15:0] shf_res;
      logic aw_got;
      logic [5:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cfalc_state_type;

endpackage : cfalc_pkg

/* test/cfalc_core_monitor.sv */
// Port checks for the flow and loop controller.
// Assumes one clock domain; bound to the design's top module below.
`timescale 1ns/1ps
`default_nettype none
module cfalc_core_monitor
   import cfalc_pkg::*;
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire cfalc_instr_type instr, // Offered instruction
   input wire logic instr_ready, // Taken this cycle
   input wire cfalc_ctl_type ctl // Control strobes
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic take;
   assign take = instr.valid && instr_ready;

   // ----------------------------------------------------------------
   // Flow types
   // ----------------------------------------------------------------
   flow_flush_a: assert property (
      take && instr.cls == IC_FLOW |=> ctl.pc_inc && ctl.fetch_en && !instr_ready)
      else $error("flow change without flush cycle");
   double_second_a: assert property (
      take && instr.cls == IC_DOUBLE |=> ctl.data_second && !instr_ready)
      else $error("double access missing second cycle");
   table_hold_a: assert property (
      take && instr.cls == IC_TABLE |=>
      ctl.table_access && ctl.ir_hold && !ctl.fetch_en && !instr_ready)
      else $error("table access did not hold fetch");
   operand_word_a: assert property (
      take && instr.cls == IC_TWO_WORD |=> ctl.operand_fetch && !instr_ready)
      else $error("second word not taken as operand");
   orphan_nop_a: assert property (
      take && instr.cls == IC_ORPHAN |-> ctl.exec_nop)
      else $error("orphan word not run as nop");
   dep_stall_a: assert property (
      ctl.stall |-> !instr_ready && !ctl.pc_inc && !ctl.fetch_en ##1 instr_ready)
      else $error("stall cycle malformed");

   // ----------------------------------------------------------------
   // Loop control
   // ----------------------------------------------------------------
   loop_arm_a: assert property (
      take && instr.cls == IC_LOOP_LIT && instr.lit != 14'h0000 |=> ctl.srl_out[4])
      else $error("loop flag not set");
   loop_zero_a: assert property (
      take && instr.cls == IC_LOOP_LIT && instr.lit == 14'h0000 |=> !ctl.srl_out[4])
      else $error("zero loop set the flag");
   loop_hold_a: assert property (
      ctl.loop_exec && !ctl.pc_inc |-> !ctl.fetch_en && ctl.srl_out[4])
      else $error("pc not held inside loop");
   loop_end_a: assert property (
      ctl.loop_exec && ctl.pc_inc |=> !ctl.srl_out[4])
      else $error("flag kept after last run");
   except_push_a: assert property (
      take && instr.cls == IC_EXCEPT |-> ctl.push_srl ##1 !ctl.srl_out[4])
      else $error("exception entry wrong");
   return_pop_a: assert property (
      take && instr.cls == IC_RETURN |=> ctl.pop_srl ##1 ctl.fetch_en && !instr_ready
      ##1 ctl.srl_out[4] == $past(instr.popped_srl[4]))
      else $error("return sequence wrong");
endmodule : cfalc_core_monitor

bind cfalc_core cfalc_core_monitor u_mon (.aclk, .aresetn, .instr, .instr_ready, .ctl);
`default_nettype wire

/* test/test_cpu_flow_and_loop_control.sv */
// Self-checking bench for the flow and loop controller.
// Assumes the port monitor binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_flow_and_loop_control
   import cfalc_pkg::*;
();
   // ----------------------------------------------------------------
   // Stimulus and scoreboard state
   // ----------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   cfalc_instr_type instr = '0;
   logic instr_ready;
   cfalc_ctl_type ctl;
   logic [5:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b1;
   logic [5:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b1;
   logic [33:0] exp_q[$];
   logic [31:0] runs;
   logic took_inc;
   int cyc;
   int miscompares = 0;
   int samples_checked = 0;
   event runs_evt;
   cfalc_iclass_type seq[8] = '{IC_SINGLE, IC_FLOW, IC_DOUBLE, IC_TABLE,
      IC_TWO_WORD, IC_ORPHAN, IC_SINGLE, IC_SINGLE};

   initial
   begin
      forever #2 aclk = ~aclk;
   end

   cfalc_core u_dut (.aclk, .aresetn, .instr, .instr_ready, .ctl, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   task automatic compare(input logic [33:0] got);
      logic [33:0] e;
      e = exp_q.pop_front();
      samples_checked++;
      if (got !== e)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
      end
   endtask : compare

   always @(posedge aclk)
   begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         compare({s_axi_bresp, 32'h0});
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         compare({s_axi_rresp, s_axi_rdata});
   end

   always @(runs_evt)
      compare({2'h0, runs});

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
   endtask : axi_wr

   task automatic axi_rd(input logic [5:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
   endtask : axi_rd

   // Hold one instruction until it is taken
   task automatic issue(input cfalc_iclass_type c, input logic [15:0] v, input logic [1:0] f);
      int n;
      instr <= '{valid: 1'b1, cls: c, raw_dep: f[0], program_space_window: f[1], lit: v[13:0], wreg: v,
         popped_srl: v[7:0]};
      for (n = 0; n < 20; n++)
      begin
         @(posedge aclk);
         if (instr_ready === 1'b1)
            break;
      end
      took_inc = ctl.pc_inc;
      cyc = n + 1;
      if (n == 20)
         miscompares++;
   endtask : issue

   task automatic note_runs(input int e, input int g);
      exp_q.push_back(34'(e));
      runs = 32'(g);
      -> runs_evt;
   endtask : note_runs

   // Repeat the target until the pc moves on
   task automatic targets(input logic [1:0] f, input int e);
      int k;
      for (k = 1; k < 40; k++)
      begin
         issue(IC_SINGLE, 16'h0010, k == 1 ? f : 2'b00);
         if (took_inc === 1'b1)
            break;
      end
      note_runs(e, k);
   endtask : targets

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // Tests need under 1000 cycles
   initial
   begin
      #100000;
      miscompares++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      int i;
      int tot;
      logic [15:0] v;
      logic [15:0] e;
      logic [3:0] a;
      void'($urandom(42768));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 4; i++)
         axi_rd(6'(4 * i), {RESP_OKAY, 32'h0});
      axi_wr(OFS_LOOP_COUNT, 32'hFFFF_FFFF, RESP_OKAY);
      axi_rd(OFS_LOOP_COUNT, {RESP_OKAY, 32'h0000_3FFF});
      axi_wr(OFS_LOOP_COUNT, 32'h0, RESP_OKAY);
      axi_wr(OFS_STATUS, 32'h0000_00FF, RESP_OKAY);
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0000_00EF});
      axi_wr(OFS_STATUS, 32'h0, RESP_OKAY);
      axi_wr(6'h10, 32'h1, RESP_SLVERR);
      axi_rd(6'h14, {RESP_SLVERR, 32'h0});
      $display("register test done");
      for (i = 0; i < 4; i++)
      begin
         v = 16'($urandom());
         a = (i == 0) ? 4'hF : 4'($urandom());
         v[15] |= (i == 0);
         case (i)
            0: e = $signed(v) >>> a;
            1: e = v >> a;
            2: e = v << a;
            default: e = v;
         endcase
         axi_wr(OFS_SHIFT_CTRL, {10'h0, 2'(i), a, v}, RESP_OKAY);
         axi_rd(OFS_SHIFT_RES, {RESP_OKAY, 16'h0, e});
      end
      $display("shifter test done");
      tot = 0;
      for (i = 0; i < 8; i++)
      begin
         issue(seq[i], 16'h0, {1'b0, i == 6});
         tot += cyc;
      end
      note_runs(13, tot);
      $display("flow test done");
      issue(IC_LOOP_LIT, 16'h0, 2'b00);
      targets(2'b00, 1);
      v = 16'(1 + $urandom_range(6));
      issue(IC_LOOP_LIT, v, 2'b00);
      targets(2'b00, int'(v) + 1);
      v = 16'(1 + $urandom_range(6));
      issue(IC_LOOP_REG, v, 2'b00);
      targets(2'b00, int'(v) + 1);
      $display("loop test done");
      issue(IC_LOOP_LIT, 16'h0005, 2'b00);
      issue(IC_SINGLE, 16'h0, 2'b00);
      issue(IC_SINGLE, 16'h0, 2'b00);
      instr <= '0;
      axi_wr(OFS_STATUS, 32'h0, RESP_OKAY);
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0010});
      issue(IC_EXCEPT, 16'h0, 2'b00);
      instr <= '0;
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0});
      axi_rd(OFS_LOOP_COUNT, {RESP_OKAY, 32'h0000_0003});
      axi_wr(OFS_LOOP_COUNT, 32'h0, RESP_OKAY);
      issue(IC_RETURN, 16'h0010, 2'b00);
      targets(2'b10, 1);
      instr <= '0;
      @(posedge aclk);
      note_runs(4, cyc);
      axi_rd(OFS_STATUS, {RESP_OKAY, 32'h0});
      $display("interrupt test done");
      conclude();
   end
endmodule : test_cpu_flow_and_loop_control
`default_nettype wire
